// file: rtl/bpc_pwm.sv
`timescale 1ns/10ps
// Notes on behaviour
// - one 10-bit counter; period and three duty values are 10-bit software values.
// - align code 00/01 edge aligned, 10 and 11 both center aligned; the low align bit has no effect.
// - counter clock is system clock divided by 1, 2, 4 or 8.
// - enable low stops counting and forces the modulated outputs off.
// - center duty-match event gated by direction field: none, up, down, both.
// - with reload set, period and duties go active only at overflow or underflow.
// - period and duty registers read back as zero.
// - high byte write only fills a hidden 2-bit holding buffer.
// - low byte write stores low byte and copies held bits into high byte.
// - two read-only registers show the live counter, low 8 and high 2 bits.
// - mirror set with reload: phase 0 duty writes also load phases 1 and 2.
// - sync-update enable with reload commits all three duties together.
// - sync request makes hardware commit all duties, then clears the request.
// - fast change clear: new phase takes effect at end of the period.
// - fast change set: new phase takes effect immediately.
// - high and low drive of one pair both on forces all drives off.
// - edge period is value plus one clocks, duty is value; period never zero.
// - center period is twice the value, duty twice the value minus one.
module bpc_pwm
   import bpc_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [5:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [5:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic [2:0]       modulated_output,
   output logic [5:0]       gate_drive,
   output logic             duty_match_event,
   output logic             period_event
);
   // bus write and read path
   logic [5:0]  awaddr_q;
   logic        aw_have_q;
   logic [31:0] wdata_q;
   logic        wstrb0_q;
   logic        w_have_q;
   logic        wr_fire;
   logic        wr_ok;
   logic [5:0]  araddr;
   logic        rd_ok;
   logic [31:0] rd_data;

   // software registers
   logic [7:0]  ctrl_q;
   logic [3:0]  sync_q;
   logic [1:0]  hold_q;
   logic [9:0]  prd_sw_q;
   logic [9:0]  duty_sw_q [3];
   logic [9:0]  prd_act_q;
   logic [9:0]  duty_act_q [3];
   logic [5:0]  phase_sw_q;
   logic [5:0]  phase_act_q;
   logic        fault_q;

   // counter
   logic [9:0]  cnt_q;
   logic        down_q;
   logic [2:0]  div_q;
   logic        tick;
   logic        wrap;
   logic        center;
   logic        enable;
   logic        reload;
   logic [2:0]  pwm_raw;
   logic [5:0]  drive_raw;
   logic        clash;
   logic        su_req_set;
   logic        su_commit;

   assign enable = ctrl_q[BPC_F_ENABLE];
   assign reload = ctrl_q[BPC_F_RELOAD];
   assign center = ctrl_q[BPC_F_ALIGN_HI];
   assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
   assign wr_ok = wr_fire && wstrb0_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q     <= 1'b0;
         w_have_q      <= 1'b0;
         awaddr_q      <= 6'h00;
         wdata_q       <= 32'h0;
         wstrb0_q      <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= BPC_RESP_OKAY;
      end else begin
         s_axi_awready <= !aw_have_q && !s_axi_awready && !s_axi_bvalid;
         s_axi_wready  <= !w_have_q && !s_axi_wready && !s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb0_q <= s_axi_wstrb[0];
            s_axi_wready <= 1'b0;
         end
         if (wr_fire) begin
            aw_have_q    <= 1'b0;
            w_have_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awaddr_q > BPC_A_PHASE || awaddr_q == BPC_A_CNTL ||
                             awaddr_q == BPC_A_CNTH) ? BPC_RESP_SLVERR : BPC_RESP_OKAY;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // read path: one outstanding read, answered at the same edge that takes the address
   assign araddr = s_axi_araddr;
   assign rd_ok  = araddr <= BPC_A_STAT;
   always_comb begin
      rd_data = 32'h0;
      case (araddr)
         BPC_A_CTRL:  rd_data = {24'h0, ctrl_q};
         BPC_A_SYNC:  rd_data = {28'h0, sync_q};
         BPC_A_CNTL:  rd_data = {24'h0, cnt_q[7:0]};
         BPC_A_CNTH:  rd_data = {30'h0, cnt_q[9:8]};
         BPC_A_PHASE: rd_data = {26'h0, phase_sw_q};
         BPC_A_STAT:  rd_data = {29'h0, fault_q, down_q, enable};
         default:     rd_data = 32'h0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= BPC_RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_data;
            s_axi_rresp   <= rd_ok ? BPC_RESP_OKAY : BPC_RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // control registers; hardware clear of the sync request loses to a software set
   assign su_req_set = wr_ok && awaddr_q == BPC_A_SYNC && wdata_q[BPC_F_SU_REQ];
   assign su_commit  = sync_q[BPC_F_SU_REQ] && sync_q[BPC_F_SU_EN] && reload && wrap;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q     <= BPC_CTRL_RST;
         sync_q     <= BPC_SYNC_RST;
         phase_sw_q <= 6'h00;
      end else begin
         if (wr_ok && awaddr_q == BPC_A_CTRL) begin
            ctrl_q <= wdata_q[7:0];
         end
         if (wr_ok && awaddr_q == BPC_A_PHASE) begin
            phase_sw_q <= wdata_q[5:0];
         end
         if (wr_ok && awaddr_q == BPC_A_SYNC) begin
            sync_q <= wdata_q[3:0];
         end else if (su_commit) begin
            sync_q[BPC_F_SU_REQ] <= 1'b0;
         end
         if (su_req_set) begin
            sync_q[BPC_F_SU_REQ] <= 1'b1;
         end
      end
   end

   // period and duty buffers with two-step byte loading
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hold_q   <= 2'b00;
         prd_sw_q <= BPC_VAL_RST;
         for (int i = 0; i < 3; i++) begin
            duty_sw_q[i] <= BPC_VAL_RST;
         end
      end else if (wr_ok) begin
         case (awaddr_q)
            BPC_A_D0H, BPC_A_D1H, BPC_A_D2H, BPC_A_PRH: begin
               hold_q <= wdata_q[1:0];
            end
            BPC_A_PRL: begin
               prd_sw_q <= {hold_q, wdata_q[7:0]};
            end
            BPC_A_D0L: begin
               duty_sw_q[0] <= {hold_q, wdata_q[7:0]};
               if (sync_q[BPC_F_MIRROR] && reload) begin
                  duty_sw_q[1] <= {hold_q, wdata_q[7:0]};
                  duty_sw_q[2] <= {hold_q, wdata_q[7:0]};
               end
            end
            BPC_A_D1L: begin
               duty_sw_q[1] <= {hold_q, wdata_q[7:0]};
            end
            BPC_A_D2L: begin
               duty_sw_q[2] <= {hold_q, wdata_q[7:0]};
            end
            default: begin
               hold_q <= hold_q;
            end
         endcase
      end
   end

   // counter clock divider
   always_ff @(posedge aclk) begin
      if (!aresetn || !enable) begin
         div_q <= 3'h0;
      end else begin
         div_q <= div_q + 3'h1;
      end
   end

   always_comb begin
      case (ctrl_q[BPC_F_CKS_LO +: 2])
         2'b00:   tick = enable;
         2'b01:   tick = enable && div_q[0];
         2'b10:   tick = enable && div_q[1:0] == 2'b11;
         default: tick = enable && div_q == 3'b111;
      endcase
   end

   // wrap marks overflow at the top in edge mode, underflow as the count drops from one to zero in center mode
   assign wrap = tick && (center ? (down_q && cnt_q <= 10'h001)
                                 : (cnt_q >= prd_act_q));

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q  <= 10'h000;
         down_q <= 1'b0;
      end else if (!enable) begin
         cnt_q  <= 10'h000;
         down_q <= 1'b0;
      end else if (tick) begin
         if (!center) begin
            cnt_q  <= wrap ? 10'h000 : cnt_q + 10'h001;
            down_q <= 1'b0;
         end else if (!down_q) begin
            if (cnt_q >= prd_act_q) begin
               down_q <= 1'b1;
               // a zero period must not roll the count over to the top
               cnt_q  <= (cnt_q == 10'h000) ? 10'h000 : cnt_q - 10'h001;
            end else begin
               cnt_q <= cnt_q + 10'h001;
            end
         end else if (wrap) begin
            // bottom is visited once, so a period is exactly 2*period ticks
            cnt_q  <= 10'h000;
            down_q <= 1'b0;
         end else begin
            cnt_q <= cnt_q - 10'h001;
         end
      end
   end

   // active values; with the sync mode armed, duties move only on a request
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prd_act_q <= BPC_VAL_RST;
         for (int i = 0; i < 3; i++) begin
            duty_act_q[i] <= BPC_VAL_RST;
         end
      end else if (reload && wrap) begin
         prd_act_q <= prd_sw_q;
         if (!sync_q[BPC_F_SU_EN] || su_commit) begin
            for (int i = 0; i < 3; i++) begin
               duty_act_q[i] <= duty_sw_q[i];
            end
         end
      end
   end

   // phase pattern: fast mode follows at once, otherwise at the period boundary
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         phase_act_q <= 6'h00;
      end else if (sync_q[BPC_F_FAST] || wrap || !enable) begin
         phase_act_q <= phase_sw_q;
      end
   end

   // edge: high while count below duty; center: 2*duty-1 clocks around zero
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         if (center) begin
            pwm_raw[i] = (duty_act_q[i] != 10'h000) && (cnt_q < duty_act_q[i]);
         end else begin
            pwm_raw[i] = cnt_q < duty_act_q[i];
         end
         drive_raw[2*i]   = phase_act_q[2*i] && pwm_raw[i];
         drive_raw[2*i+1] = phase_act_q[2*i+1] && !pwm_raw[i];
      end
   end

   assign clash = (drive_raw[0] && drive_raw[1]) || (drive_raw[2] && drive_raw[3]) ||
                  (drive_raw[4] && drive_raw[5]);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         modulated_output <= 3'b000;
         gate_drive       <= 6'h00;
         fault_q          <= 1'b0;
         duty_match_event <= 1'b0;
         period_event     <= 1'b0;
      end else begin
         modulated_output <= enable ? pwm_raw : 3'b000;
         gate_drive       <= (enable && !clash) ? drive_raw : 6'h00;
         fault_q          <= enable && clash;
         period_event     <= wrap;
         case (bpc_irq_t'(ctrl_q[BPC_F_IRQ_LO +: 2]))
            BPC_IRQ_UP:   duty_match_event <= center && tick && !down_q &&
                                              cnt_q == duty_act_q[0];
            BPC_IRQ_DOWN: duty_match_event <= center && tick && down_q &&
                                              cnt_q == duty_act_q[0];
            BPC_IRQ_BOTH: duty_match_event <= center && tick && cnt_q == duty_act_q[0];
            default:      duty_match_event <= 1'b0;
         endcase
      end
   end
endmodule

// file: pkg/bpc_pkg.sv
package bpc_pkg;
   localparam int          BPC_AW          = 6;
   // register byte addresses on the bus
   localparam logic [5:0]  BPC_A_CTRL      = 6'h00;
   localparam logic [5:0]  BPC_A_SYNC      = 6'h04;
   localparam logic [5:0]  BPC_A_D0L       = 6'h08;
   localparam logic [5:0]  BPC_A_D0H       = 6'h0c;
   localparam logic [5:0]  BPC_A_D1L       = 6'h10;
   localparam logic [5:0]  BPC_A_D1H       = 6'h14;
   localparam logic [5:0]  BPC_A_D2L       = 6'h18;
   localparam logic [5:0]  BPC_A_D2H       = 6'h1c;
   localparam logic [5:0]  BPC_A_PRL       = 6'h20;
   localparam logic [5:0]  BPC_A_PRH       = 6'h24;
   localparam logic [5:0]  BPC_A_CNTL      = 6'h28;
   localparam logic [5:0]  BPC_A_CNTH      = 6'h2c;
   localparam logic [5:0]  BPC_A_PHASE     = 6'h30;
   localparam logic [5:0]  BPC_A_STAT      = 6'h34;
   // control register fields
   localparam int          BPC_F_RELOAD    = 0;
   localparam int          BPC_F_IRQ_LO    = 1;
   localparam int          BPC_F_ENABLE    = 3;
   localparam int          BPC_F_CKS_LO    = 4;
   localparam int          BPC_F_ALIGN_HI  = 7;
   // sync control fields
   localparam int          BPC_F_MIRROR    = 0;
   localparam int          BPC_F_SU_EN     = 1;
   localparam int          BPC_F_SU_REQ    = 2;
   localparam int          BPC_F_FAST      = 3;
   localparam logic [7:0]  BPC_CTRL_RST    = 8'h00;
   localparam logic [3:0]  BPC_SYNC_RST    = 4'h0;
   localparam logic [9:0]  BPC_VAL_RST     = 10'h000;
   localparam logic [1:0]  BPC_RESP_OKAY   = 2'b00;
   localparam logic [1:0]  BPC_RESP_SLVERR = 2'b10;
   typedef enum logic [1:0] {BPC_IRQ_NONE, BPC_IRQ_UP, BPC_IRQ_DOWN, BPC_IRQ_BOTH} bpc_irq_t;
endpackage

// file: tb/bpc_pwm_sva.sv
`timescale 1ns/10ps
module bpc_pwm_sva
   import bpc_pkg::*;
(
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic [5:0]  s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0]  s_axi_wstrb,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [2:0]  modulated_output,
   input wire logic [5:0]  gate_drive,
   input wire logic        duty_match_event
);
   logic [7:0] ctrl_q;
   logic [5:0] wr_addr_q;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   // this copy leads the design by a cycle, so the past depth of 4 gives slack
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q <= BPC_CTRL_RST;
         wr_addr_q <= 6'h00;
      end else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready) begin
         wr_addr_q <= s_axi_awaddr;
         if (s_axi_awaddr == BPC_A_CTRL && s_axi_wstrb[0]) begin
            ctrl_q <= s_axi_wdata[7:0];
         end
      end
   end
   AST_NO_CLASH: assert property ((gate_drive & (gate_drive >> 1) & 6'h15) == 6'h00)
      else $error("gate pair on at both sides");
   AST_B_AFTER_W: assert property (s_wr_take |-> ##[1:2] s_axi_bvalid)
      else $error("write response missing");
   AST_B_STANDS: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   AST_R_AFTER_AR: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   AST_R_STANDS: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   AST_AR_READY: assert property (s_axi_arvalid && !s_axi_rvalid |-> ##[0:2] s_axi_arready)
      else $error("read address not taken");
   AST_EN_OFF: assert property (!ctrl_q[3] && !$past(ctrl_q[3], 4) |-> modulated_output == 3'b000)
      else $error("output active while off");
   AST_EDGE_NO_DUTY: assert property (!ctrl_q[7] && !$past(ctrl_q[7], 4) |-> !duty_match_event)
      else $error("duty event in edge mode");
   AST_IRQ_NONE: assert property (ctrl_q[2:1] == 2'b00 && $past(ctrl_q[2:1], 4) == 2'b00 |-> !duty_match_event)
      else $error("duty event while gated off");
   AST_RO_WR_ERR: assert property (s_axi_bvalid && (wr_addr_q == BPC_A_CNTL || wr_addr_q == BPC_A_CNTH) |-> s_axi_bresp == BPC_RESP_SLVERR)
      else $error("counter write not refused");
endmodule
bind bpc_pwm bpc_pwm_sva chk_u (.*);

// file: tb/bpc_gate_pairs.sv
`timescale 1ns/10ps
module bpc_gate_pairs
   import bpc_pkg::*;
(
   input  wire logic [5:0] gate_drive,
   output logic      [2:0] high_on,
   output logic            shoot_through
);
   // dead time is inserted by the stage after this block; the model assumes none
   // a pair conducts through its high side only while its low side is off
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         high_on[i] = gate_drive[2*i] & ~gate_drive[2*i+1];
      end
   end
   assign shoot_through = |(gate_drive & (gate_drive >> 1) & 6'h15);
endmodule

// file: tb/bldc_pwm_counter_control_tb.sv
`timescale 1ns/10ps
module bldc_pwm_counter_control_tb
   import bpc_pkg::*;
();
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [5:0]  s_axi_awaddr = 6'h00;
   logic [5:0]  s_axi_araddr = 6'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic        s_axi_awvalid = 1'b0;
   logic        s_axi_wvalid = 1'b0;
   logic        s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0;
   logic        s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic [2:0]  modulated_output, high_on;
   logic [5:0]  gate_drive;
   logic        duty_match_event, period_event, shoot_through;
   int          failures = 0;
   int          num_checks = 0;
   bpc_pwm dut_u (.*);
   bpc_gate_pairs pair_u (.gate_drive(gate_drive), .high_on(high_on), .shoot_through(shoot_through));
   always #50 aclk = ~aclk;
   task automatic print_verdict;
      if (failures == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      // only the watchdog ends a wait for the response
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b1;
      @(posedge aclk);
      s_axi_bready <= 1'b0;
      chk({30'h0, s_axi_bresp}, {30'h0, er});
   endtask
   task automatic rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b1;
      @(posedge aclk);
      s_axi_rready <= 1'b0;
      d = s_axi_rdata;
      r = s_axi_rresp;
   endtask
   task automatic wv(input logic [5:0] lo, input logic [9:0] v);
      wr(lo + 6'h04, {30'h0, v[9:8]}, BPC_RESP_OKAY);
      wr(lo, {24'h0, v[7:0]}, BPC_RESP_OKAY);
   endtask
   task automatic span(output logic [31:0] len, h0, h1, m);
      int n;
      // the first boundary may close a period begun under old settings
      repeat (2) begin
         n = 0;
         do begin
            @(posedge aclk);
            n++;
         end while (period_event !== 1'b1 && n < 5000);
      end
      len = 0;
      h0 = 0;
      h1 = 0;
      m = 0;
      do begin
         @(posedge aclk);
         len++;
         h0 = h0 + {31'h0, high_on[0]};
         h1 = h1 + {31'h0, high_on[1]};
         m = m + {31'h0, duty_match_event};
      end while (period_event !== 1'b1 && len < 5000);
   endtask
   task automatic t_regs;
      logic [31:0] d;
      logic [1:0]  r;
      rd(BPC_A_CTRL, d, r);
      chk(d, 32'h0);
      wv(BPC_A_D0L, 10'h3ff);
      rd(BPC_A_D0L, d, r);
      chk(d, 32'h0);
      rd(6'h38, d, r);
      chk({30'h0, r}, {30'h0, BPC_RESP_SLVERR});
      wr(BPC_A_CNTL, 32'h5, BPC_RESP_SLVERR);
   endtask
   task automatic t_edge;
      logic [31:0] len, h0, h1, m;
      wv(BPC_A_PRL, 10'h104);
      wv(BPC_A_D0L, 10'h041);
      wr(BPC_A_PHASE, 32'h3f, BPC_RESP_OKAY);
      for (int c = 0; c < 4; c++) begin
         wr(BPC_A_CTRL, 32'h09 | 32'(c << 4) | (c == 1 ? 32'h40 : 32'h0), BPC_RESP_OKAY);
         span(len, h0, h1, m);
         chk(len, 32'h105 << c);
         chk(h0, 32'h41 << c);
      end
   endtask
   task automatic t_center;
      logic [31:0] len, h0, h1, m;
      for (int k = 0; k < 5; k++) begin
         wr(BPC_A_CTRL, (k < 4 ? 32'hc9 : 32'h8f) | 32'(k % 4 << 1), BPC_RESP_OKAY);
         span(len, h0, h1, m);
         chk(len, 32'h208);
         chk(h0, 32'h81);
         chk(m, 32'(k == 0 ? 0 : (k == 3 || k == 4) ? 2 : 1));
      end
   endtask
   task automatic t_sync;
      logic [31:0] len, h0, h1, m, d;
      logic [1:0]  r;
      wr(BPC_A_CTRL, 32'h09, BPC_RESP_OKAY);
      wr(BPC_A_SYNC, 32'h01, BPC_RESP_OKAY);
      wv(BPC_A_D0L, 10'h0c3);
      span(len, h0, h1, m);
      chk(h1, 32'hc3);
      wr(BPC_A_SYNC, 32'h02, BPC_RESP_OKAY);
      wv(BPC_A_D1L, 10'h010);
      span(len, h0, h1, m);
      chk(h1, 32'hc3);
      wr(BPC_A_SYNC, 32'h06, BPC_RESP_OKAY);
      span(len, h0, h1, m);
      chk(h1, 32'h10);
      rd(BPC_A_SYNC, d, r);
      chk(d, 32'h2);
   endtask
   task automatic t_stop;
      logic [31:0] a, b;
      logic [1:0]  r;
      wr(BPC_A_SYNC, 32'h08, BPC_RESP_OKAY);
      wr(BPC_A_PHASE, 32'h00, BPC_RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk({26'h0, gate_drive}, 32'h0);
      // start just after a boundary so the next one is a full period away
      do begin
         @(posedge aclk);
      end while (period_event !== 1'b1);
      wr(BPC_A_SYNC, 32'h00, BPC_RESP_OKAY);
      wr(BPC_A_PHASE, 32'h3f, BPC_RESP_OKAY);
      chk({26'h0, gate_drive}, 32'h0);
      do begin
         @(posedge aclk);
      end while (period_event !== 1'b1);
      @(posedge aclk);
      chk({31'h0, gate_drive != 6'h00}, 32'h1);
      rd(BPC_A_CNTL, a, r);
      rd(BPC_A_CNTH, b, r);
      chk({31'h0, b <= 32'h1}, 32'h1);
      rd(BPC_A_CNTL, b, r);
      chk({31'h0, b != a}, 32'h1);
      wr(BPC_A_CTRL, 32'h01, BPC_RESP_OKAY);
      repeat (3) @(posedge aclk);
      chk({29'h0, modulated_output}, 32'h0);
      rd(BPC_A_CNTL, a, r);
      rd(BPC_A_CNTL, b, r);
      chk(b, a);
      chk({31'h0, shoot_through}, 32'h0);
   endtask
   initial begin
      #5_000_000;
      failures++;
      print_verdict;
   end
   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs;
      t_edge;
      t_center;
      t_sync;
      t_stop;
      print_verdict;
   end
endmodule
